// ===== pkg/a20_gate_fast_reset_map.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: 250 MHz controller clock
// Notes: definitions only
`ifndef A20_GATE_FAST_RESET_MAP_SVH
`define A20_GATE_FAST_RESET_MAP_SVH

`define FW_ADDR_W 15
`define AUX_HOST_DATA_OUT_ADDR 15'h7FFA
`define FIRMWARE_GATE_CONTROL_ADDR 15'h7FFB
`define GATE_LATCH_SET_STROBE_ADDR 15'h7FFE
`define GATE_LATCH_CLEAR_STROBE_ADDR 15'h7FFF
`define FIRMWARE_GATE_CONTROL_RESET 8'h01
`define FAST_RESET_A20_PORT_ADDR 16'h0092
`define FAST_RESET_A20_PORT_RESET 8'h00
`define GATE_CMD_BYTE 8'hD1
`define GATE_TRAIL_CMD_BYTE 8'hFF
`define GATE_DATA_BIT 1
`define PORT_RESET_BIT 0
`define PORT_GATE_BIT 1
`define CLK_MHZ 250
`define RESET_DELAY_US 14
`define RESET_WIDTH_US 6
`define RESET_DELAY_CYCLES (`RESET_DELAY_US * `CLK_MHZ)
`define RESET_WIDTH_CYCLES (`RESET_WIDTH_US * `CLK_MHZ)
`define RESET_CNT_W 12

`endif

// ===== pkg/a20_gate_fast_reset_pkg.sv
// Purpose: types for the gate and fast reset block
// Assumes: nothing
// Notes: gray-coded pulse states; gate state codes go 3 to 0, two bits at once
package a20_gate_fast_reset_pkg;
    typedef enum logic [1:0]
    {
        GATE_IDLE = 2'h0,
        GATE_WAIT_DATA = 2'h1,
        GATE_WAIT_TRAIL = 2'h3
    } gate_state_e;

    typedef enum logic [1:0]
    {
        PULSE_IDLE = 2'h0,
        PULSE_DELAY = 2'h1,
        PULSE_LOW = 2'h3,
        PULSE_DONE = 2'h2
    } pulse_state_e;
endpackage : a20_gate_fast_reset_pkg

// ===== design/alt_reset_pulse_gen.sv
// Purpose: timed alternate host reset pulse
// Assumes: level request from the fast-reset port bit
// Notes: one pulse per rising edge of the request bit seen while idle
`timescale 1ns/1ns
`default_nettype none
`include "a20_gate_fast_reset_map.svh"

module alt_reset_pulse_gen
(
    input wire logic clk_in,
    input wire logic arst_n_in,
    input wire logic request_in,
    output logic pulse_n_out
);

    a20_gate_fast_reset_pkg::pulse_state_e state_reg;
    logic [`RESET_CNT_W-1:0] count_reg;
    logic request_d_reg;
    logic rise;

    assign rise = request_in & ~request_d_reg;

    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            request_d_reg <= 1'b0;
        else
            request_d_reg <= request_in;
    end

    ////////////////////////////////////////////////////////////////
    // a rise while busy is dropped, not queued
    always_ff @(posedge clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_reg <= a20_gate_fast_reset_pkg::PULSE_IDLE;
            count_reg <= '0;
        end
        else
        begin
            case (state_reg)
                a20_gate_fast_reset_pkg::PULSE_IDLE:
                    if (rise)
                    begin
                        state_reg <= a20_gate_fast_reset_pkg::PULSE_DELAY;
                        count_reg <= `RESET_CNT_W'(`RESET_DELAY_CYCLES - 1);
                    end
                a20_gate_fast_reset_pkg::PULSE_DELAY:
                    if (count_reg == '0)
                    begin
                        state_reg <= a20_gate_fast_reset_pkg::PULSE_LOW;
                        count_reg <= `RESET_CNT_W'(`RESET_WIDTH_CYCLES - 1);
                    end
                    else
                        count_reg <= count_reg - 1'b1;
                a20_gate_fast_reset_pkg::PULSE_LOW:
                    if (count_reg == '0)
                        state_reg <= a20_gate_fast_reset_pkg::PULSE_DONE;
                    else
                        count_reg <= count_reg - 1'b1;
                a20_gate_fast_reset_pkg::PULSE_DONE:
                    state_reg <= a20_gate_fast_reset_pkg::PULSE_IDLE;
                default:
                    state_reg <= a20_gate_fast_reset_pkg::PULSE_IDLE;
            endcase
        end
    end

    assign pulse_n_out = (state_reg != a20_gate_fast_reset_pkg::PULSE_LOW);

endmodule : alt_reset_pulse_gen
`default_nettype wire

// ===== design/a20_gate_fast_reset.sv
// Purpose: address-line-20 gate and fast host reset logic
// Assumes: host and firmware strobes are one-cycle, synchronous
// Notes: keyboard flag machinery lives elsewhere; this block only
//        suppresses or requests input-full setting and holds the command/data flag
`timescale 1ns/1ns
`default_nettype none
`include "a20_gate_fast_reset_map.svh"

module a20_gate_fast_reset
(
    input wire logic REF_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic SECONDARY_POR_N_IN,
    input wire logic SYSTEM_RESET_IN,
    // host keyboard interface write
    input wire logic KBD_HOST_WR_IN,
    input wire logic CMD_DATA_SELECT_ADDR_IN,
    input wire logic [7:0] KBD_HOST_DATA_IN,
    // host ISA port access
    input wire logic [15:0] ISA_ADDR_IN,
    input wire logic ISA_WR_IN,
    input wire logic ISA_RD_IN,
    input wire logic [7:0] ISA_WDATA_IN,
    output logic [7:0] ISA_RDATA_OUT,
    output logic ISA_RDATA_OE_N_OUT,
    input wire logic PORT_ENABLE_IN,
    // firmware bus
    input wire logic [`FW_ADDR_W-1:0] FW_ADDR_IN,
    input wire logic FW_WR_IN,
    input wire logic FW_RD_IN,
    input wire logic [7:0] FW_WDATA_IN,
    output logic [7:0] FW_RDATA_OUT,
    output logic FW_RDATA_VALID_OUT,
    input wire logic FIRMWARE_ASSIST_ENABLE_IN,
    // pin, resets and keyboard flags
    input wire logic MISC_PIN_SELECT_IN,
    input wire logic GPIO_OUT_VALUE_IN,
    input wire logic KBC_RESET_PULSE_N_IN,
    output logic GATE_GPIO_PIN_OUT,
    output logic ADDR_LINE_MASK_GATE_OUT,
    output logic HOST_CPU_RESET_OUT,
    output logic CMD_DATA_FLAG_OUT,
    output logic INPUT_FULL_SET_OUT,
    output logic KBD_OUT_FULL_SUPPRESS_OUT
);

    a20_gate_fast_reset_pkg::gate_state_e gate_state_reg;
    a20_gate_fast_reset_pkg::gate_state_e gate_state_next;
    logic host_latch_reg;
    logic host_latch_next;
    logic fw_gate_reg;
    logic cmd_data_flag_reg;
    logic [1:0] port_bits_reg;
    logic alt_reset_pulse_n;
    logic kbc_gate;
    logic alt_gate_signal;
    logic gate;
    logic is_gate_cmd;
    logic is_trail_cmd;
    logic port_hit;
    logic ibf_set;
    logic hide;
    logic fw_wr_ctrl;
    logic fw_wr_set;
    logic fw_wr_clr;

    function automatic logic fw_hit(input logic [`FW_ADDR_W-1:0] addr, input logic [`FW_ADDR_W-1:0] target);
        fw_hit = (addr == target);
    endfunction : fw_hit

    ////////////////////////////////////////////////////////////////
    // decode
    assign is_gate_cmd = KBD_HOST_WR_IN & CMD_DATA_SELECT_ADDR_IN & (KBD_HOST_DATA_IN == `GATE_CMD_BYTE);
    assign is_trail_cmd = KBD_HOST_WR_IN & CMD_DATA_SELECT_ADDR_IN & (KBD_HOST_DATA_IN == `GATE_TRAIL_CMD_BYTE);
    assign port_hit = PORT_ENABLE_IN & (ISA_ADDR_IN == `FAST_RESET_A20_PORT_ADDR);
    assign fw_wr_ctrl = FW_WR_IN & fw_hit(FW_ADDR_IN, `FIRMWARE_GATE_CONTROL_ADDR);
    assign fw_wr_set = FW_WR_IN & fw_hit(FW_ADDR_IN, `GATE_LATCH_SET_STROBE_ADDR);
    assign fw_wr_clr = FW_WR_IN & fw_hit(FW_ADDR_IN, `GATE_LATCH_CLEAR_STROBE_ADDR);

    ////////////////////////////////////////////////////////////////
    // gate sequence decoder
    always_comb
    begin
        gate_state_next = gate_state_reg;
        host_latch_next = host_latch_reg;
        ibf_set = 1'b0;
        hide = 1'b0;
        if (fw_wr_set)
            host_latch_next = 1'b1;
        else if (fw_wr_clr)
            host_latch_next = 1'b0;
        if (KBD_HOST_WR_IN)
        begin
            case (gate_state_reg)
                a20_gate_fast_reset_pkg::GATE_IDLE:
                    if (is_gate_cmd)
                    begin
                        hide = 1'b1;
                        gate_state_next = a20_gate_fast_reset_pkg::GATE_WAIT_DATA;
                    end
                    else
                        ibf_set = 1'b1;
                a20_gate_fast_reset_pkg::GATE_WAIT_DATA:
                    if (is_gate_cmd)
                        hide = 1'b1;
                    else if (!CMD_DATA_SELECT_ADDR_IN)
                    begin
                        hide = 1'b1;
                        host_latch_next = KBD_HOST_DATA_IN[`GATE_DATA_BIT];
                        gate_state_next = a20_gate_fast_reset_pkg::GATE_WAIT_TRAIL;
                    end
                    else
                    begin
                        ibf_set = 1'b1;
                        gate_state_next = a20_gate_fast_reset_pkg::GATE_IDLE;
                    end
                a20_gate_fast_reset_pkg::GATE_WAIT_TRAIL:
                    if (is_trail_cmd)
                    begin
                        hide = 1'b1;
                        gate_state_next = a20_gate_fast_reset_pkg::GATE_IDLE;
                    end
                    else if (is_gate_cmd)
                    begin
                        hide = 1'b1;
                        gate_state_next = a20_gate_fast_reset_pkg::GATE_WAIT_DATA;
                    end
                    else
                    begin
                        // second data byte or foreign command goes to firmware
                        ibf_set = 1'b1;
                        gate_state_next = a20_gate_fast_reset_pkg::GATE_IDLE;
                    end
                default:
                    gate_state_next = a20_gate_fast_reset_pkg::GATE_IDLE;
            endcase
        end
    end

    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            gate_state_reg <= a20_gate_fast_reset_pkg::GATE_IDLE;
        else
            gate_state_reg <= gate_state_next;
    end

    // host latch only moves on sequence or strobe
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            host_latch_reg <= 1'b1;
        else
            host_latch_reg <= host_latch_next;
    end

    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            cmd_data_flag_reg <= 1'b0;
        else if (KBD_HOST_WR_IN)
            cmd_data_flag_reg <= CMD_DATA_SELECT_ADDR_IN;
    end

    ////////////////////////////////////////////////////////////////
    // firmware gate control register
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            fw_gate_reg <= 1'(`FIRMWARE_GATE_CONTROL_RESET);
        else if (fw_wr_ctrl)
            fw_gate_reg <= FW_WDATA_IN[0];
    end

    assign kbc_gate = FIRMWARE_ASSIST_ENABLE_IN ? fw_gate_reg : host_latch_reg;

    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            FW_RDATA_OUT <= 8'h00;
            FW_RDATA_VALID_OUT <= 1'b0;
        end
        else
        begin
            FW_RDATA_VALID_OUT <= FW_RD_IN;
            if (FW_RD_IN && fw_hit(FW_ADDR_IN, `FIRMWARE_GATE_CONTROL_ADDR))
                FW_RDATA_OUT <= {7'h00, kbc_gate};
            else
                FW_RDATA_OUT <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////
    // fast-reset port
    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
            port_bits_reg <= 2'(`FAST_RESET_A20_PORT_RESET);
        else if (SYSTEM_RESET_IN || !SECONDARY_POR_N_IN)
            port_bits_reg <= 2'(`FAST_RESET_A20_PORT_RESET);
        else if (ISA_WR_IN && port_hit)
            port_bits_reg <= ISA_WDATA_IN[1:0];
    end

    always_ff @(posedge REF_CLK_IN or negedge ARST_N_IN)
    begin
        if (!ARST_N_IN)
        begin
            ISA_RDATA_OUT <= `FAST_RESET_A20_PORT_RESET;
            ISA_RDATA_OE_N_OUT <= 1'b1;
        end
        else
        begin
            ISA_RDATA_OE_N_OUT <= ~(ISA_RD_IN & port_hit);
            ISA_RDATA_OUT <= {6'h00, port_bits_reg};
        end
    end

    alt_reset_pulse_gen u_pulse
    (
        .clk_in(REF_CLK_IN),
        .arst_n_in(ARST_N_IN),
        .request_in(port_bits_reg[`PORT_RESET_BIT]),
        .pulse_n_out(alt_reset_pulse_n)
    );

    ////////////////////////////////////////////////////////////////
    // outputs
    assign alt_gate_signal = port_bits_reg[`PORT_GATE_BIT];
    assign gate = alt_gate_signal | kbc_gate;
    assign ADDR_LINE_MASK_GATE_OUT = gate;
    assign GATE_GPIO_PIN_OUT = MISC_PIN_SELECT_IN ? gate : GPIO_OUT_VALUE_IN;
    assign HOST_CPU_RESET_OUT = ~(alt_reset_pulse_n & KBC_RESET_PULSE_N_IN);
    assign CMD_DATA_FLAG_OUT = cmd_data_flag_reg;
    assign INPUT_FULL_SET_OUT = ibf_set;
    assign KBD_OUT_FULL_SUPPRESS_OUT = hide;

endmodule : a20_gate_fast_reset
`default_nettype wire

// ===== bench/kbc_reset_model.sv
// Purpose: keyboard controller reset pulse source on the far side
// Assumes: fire is a one-cycle request from the bench
// Notes: pulse length is arbitrary, not a documented figure
`timescale 1ns/1ns
`default_nettype none

module kbc_reset_model
#(
    parameter int PULSE_LEN = 8
)
(
    input wire logic clk_in,
    input wire logic fire_in,
    output logic pulse_n_out
);
    int cnt;

    always_ff @(posedge clk_in)
    begin
        if (fire_in)
            cnt <= PULSE_LEN;
        else if (cnt > 0)
            cnt <= cnt - 1;
    end

    // active low while the count runs
    assign pulse_n_out = (cnt == 0);
endmodule : kbc_reset_model
`default_nettype wire

// ===== bench/a20_gate_fast_reset_monitor.sv
// Purpose: port-level checks of the gate and fast reset block
// Assumes: one clock, async active-low reset
// Notes: attached by bind at the foot
`timescale 1ns/1ns
`default_nettype none

module gate_reset_monitor
(
    input wire logic REF_CLK_IN,
    input wire logic ARST_N_IN,
    input wire logic KBD_HOST_WR_IN,
    input wire logic CMD_DATA_SELECT_ADDR_IN,
    input wire logic [7:0] KBD_HOST_DATA_IN,
    input wire logic ISA_RD_IN,
    input wire logic PORT_ENABLE_IN,
    input wire logic [7:0] ISA_RDATA_OUT,
    input wire logic ISA_RDATA_OE_N_OUT,
    input wire logic FW_RD_IN,
    input wire logic [7:0] FW_RDATA_OUT,
    input wire logic FW_RDATA_VALID_OUT,
    input wire logic MISC_PIN_SELECT_IN,
    input wire logic GPIO_OUT_VALUE_IN,
    input wire logic KBC_RESET_PULSE_N_IN,
    input wire logic GATE_GPIO_PIN_OUT,
    input wire logic ADDR_LINE_MASK_GATE_OUT,
    input wire logic HOST_CPU_RESET_OUT,
    input wire logic INPUT_FULL_SET_OUT,
    input wire logic KBD_OUT_FULL_SUPPRESS_OUT
);
    default clocking cb @(posedge REF_CLK_IN); endclocking
    default disable iff (!ARST_N_IN);

    ////////////////////////////////////////
    a_pin_mux_gate: assert property (GATE_GPIO_PIN_OUT == (MISC_PIN_SELECT_IN ? ADDR_LINE_MASK_GATE_OUT :
        GPIO_OUT_VALUE_IN)) else $error("pin mux wrong");
    a_kbc_reset_nand: assert property (!KBC_RESET_PULSE_N_IN |-> HOST_CPU_RESET_OUT)
        else $error("keyboard reset not passed");
    a_fw_upper_zero: assert property (FW_RDATA_VALID_OUT |-> FW_RDATA_OUT[7:1] == 7'h00)
        else $error("firmware read upper bits set");
    a_fw_read_answer: assert property (FW_RD_IN |=> FW_RDATA_VALID_OUT)
        else $error("firmware read not answered");
    a_port_upper_zero: assert property (!ISA_RDATA_OE_N_OUT |-> ISA_RDATA_OUT[7:2] == 6'h00)
        else $error("port read upper bits set");
    a_port_off_float: assert property (ISA_RD_IN && !PORT_ENABLE_IN |=> ISA_RDATA_OE_N_OUT)
        else $error("disabled port drove bus");
    a_cmd_swallowed: assert property (KBD_HOST_WR_IN && CMD_DATA_SELECT_ADDR_IN && KBD_HOST_DATA_IN == 8'hD1
        |-> KBD_OUT_FULL_SUPPRESS_OUT && !INPUT_FULL_SET_OUT) else $error("gate command not swallowed");
    a_full_needs_write: assert property (!KBD_HOST_WR_IN |-> !INPUT_FULL_SET_OUT)
        else $error("input full without write");
    a_alt_pulse_holds: assert property ($rose(HOST_CPU_RESET_OUT) && KBC_RESET_PULSE_N_IN
        |=> HOST_CPU_RESET_OUT [*8]) else $error("alternate reset pulse too short");

    c_swallow: cover property (KBD_OUT_FULL_SUPPRESS_OUT);
    c_alt_reset: cover property ($rose(HOST_CPU_RESET_OUT) && KBC_RESET_PULSE_N_IN);
    c_port_read: cover property (!ISA_RDATA_OE_N_OUT);
endmodule : gate_reset_monitor

bind a20_gate_fast_reset gate_reset_monitor u_mon
(
    .REF_CLK_IN(REF_CLK_IN), .ARST_N_IN(ARST_N_IN), .KBD_HOST_WR_IN(KBD_HOST_WR_IN),
    .CMD_DATA_SELECT_ADDR_IN(CMD_DATA_SELECT_ADDR_IN), .KBD_HOST_DATA_IN(KBD_HOST_DATA_IN),
    .ISA_RD_IN(ISA_RD_IN), .PORT_ENABLE_IN(PORT_ENABLE_IN), .ISA_RDATA_OUT(ISA_RDATA_OUT),
    .ISA_RDATA_OE_N_OUT(ISA_RDATA_OE_N_OUT), .FW_RD_IN(FW_RD_IN), .FW_RDATA_OUT(FW_RDATA_OUT),
    .FW_RDATA_VALID_OUT(FW_RDATA_VALID_OUT), .MISC_PIN_SELECT_IN(MISC_PIN_SELECT_IN),
    .GPIO_OUT_VALUE_IN(GPIO_OUT_VALUE_IN), .KBC_RESET_PULSE_N_IN(KBC_RESET_PULSE_N_IN),
    .GATE_GPIO_PIN_OUT(GATE_GPIO_PIN_OUT), .ADDR_LINE_MASK_GATE_OUT(ADDR_LINE_MASK_GATE_OUT),
    .HOST_CPU_RESET_OUT(HOST_CPU_RESET_OUT), .INPUT_FULL_SET_OUT(INPUT_FULL_SET_OUT),
    .KBD_OUT_FULL_SUPPRESS_OUT(KBD_OUT_FULL_SUPPRESS_OUT)
);
`default_nettype wire

// ===== bench/test_a20_gate_fast_reset.sv
// Purpose: self-checking bench for the gate and fast reset block
// Assumes: 250 MHz clock, inputs driven 1 ns after the edge
// Notes: gate sequences, strobes, assist mode, port and pulses
`timescale 1ns/1ns
`default_nettype none
`include "a20_gate_fast_reset_map.svh"
`define CHK(nm, e, g) tests_run++; if ((g) !== (e)) begin fails++; $display("ERROR %s exp %h seen %h", nm, e, g); end

module test_a20_gate_fast_reset;
    logic clk, arst_n, por2_n, sys_rst, kwr, ksel, fwr, frd, iwr, ird, pen, asst, misc, gpio, fire, f, o, seen;
    logic sp, vld;
    logic [7:0] kd, fd, id, d;
    logic [15:0] ia;
    logic [`FW_ADDR_W-1:0] fa;
    wire logic [7:0] irdata, frdata;
    wire logic oe_n, fvalid, pin, gate, hrst, cdf, full, supp, kbc_n;
    integer seed = 56306;
    int fails = 0;
    int tests_run = 0;
    int n;

    initial
    begin
        clk = 0;
        forever #2 clk = ~clk;
    end

    a20_gate_fast_reset u_dut
    (
        .REF_CLK_IN(clk), .ARST_N_IN(arst_n), .SECONDARY_POR_N_IN(por2_n), .SYSTEM_RESET_IN(sys_rst),
        .KBD_HOST_WR_IN(kwr), .CMD_DATA_SELECT_ADDR_IN(ksel), .KBD_HOST_DATA_IN(kd), .ISA_ADDR_IN(ia),
        .ISA_WR_IN(iwr), .ISA_RD_IN(ird), .ISA_WDATA_IN(id), .ISA_RDATA_OUT(irdata), .ISA_RDATA_OE_N_OUT(oe_n),
        .PORT_ENABLE_IN(pen), .FW_ADDR_IN(fa), .FW_WR_IN(fwr), .FW_RD_IN(frd), .FW_WDATA_IN(fd),
        .FW_RDATA_OUT(frdata), .FW_RDATA_VALID_OUT(fvalid), .FIRMWARE_ASSIST_ENABLE_IN(asst),
        .MISC_PIN_SELECT_IN(misc), .GPIO_OUT_VALUE_IN(gpio), .KBC_RESET_PULSE_N_IN(kbc_n),
        .GATE_GPIO_PIN_OUT(pin), .ADDR_LINE_MASK_GATE_OUT(gate), .HOST_CPU_RESET_OUT(hrst),
        .CMD_DATA_FLAG_OUT(cdf), .INPUT_FULL_SET_OUT(full), .KBD_OUT_FULL_SUPPRESS_OUT(supp)
    );

    kbc_reset_model u_kbc (.clk_in(clk), .fire_in(fire), .pulse_n_out(kbc_n));

    ////////////////////////////////////////
    function automatic logic [7:0] port_view(input logic [7:0] w);
        return {6'h00, w[1:0]};
    endfunction : port_view

    task automatic step;
        @(posedge clk);
        #1;
    endtask : step

    task automatic report_and_stop;
        if (fails == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop

    // strobes drop after one edge, so every access leaves an idle cycle
    task automatic kbd(input logic s, input logic [7:0] v, output logic fl);
        kwr = 1;
        ksel = s;
        kd = v;
        // flags are combinational: let them settle before looking
        #1;
        fl = full;
        sp = supp;
        step;
        kwr = 0;
        step;
    endtask : kbd

    task automatic fw_wr(input logic [`FW_ADDR_W-1:0] a, input logic [7:0] v);
        fa = a;
        fd = v;
        fwr = 1;
        step;
        fwr = 0;
        step;
    endtask : fw_wr

    task automatic fw_rd(output logic [7:0] v);
        fa = `FIRMWARE_GATE_CONTROL_ADDR;
        frd = 1;
        step;
        frd = 0;
        v = frdata;
        vld = fvalid;
        step;
    endtask : fw_rd

    task automatic isa_wr(input logic [7:0] v);
        id = v;
        iwr = 1;
        step;
        iwr = 0;
        step;
    endtask : isa_wr

    task automatic isa_rd(output logic [7:0] v, output logic oe);
        ird = 1;
        step;
        ird = 0;
        oe = oe_n;
        v = irdata;
        step;
    endtask : isa_rd

    task automatic wait_rst(input logic v, output int cnt);
        cnt = 0;
        while (hrst !== v)
        begin
            step;
            cnt++;
            if (cnt > 5000)
            begin
                fails++;
                report_and_stop;
            end
        end
    endtask : wait_rst

    ////////////////////////////////////////
    initial
    begin
        {arst_n, sys_rst, kwr, ksel, fwr, frd, iwr, ird, asst, gpio, fire} = '0;
        {por2_n, pen, misc} = 3'b111;
        {kd, fd, id, fa} = '0;
        ia = `FAST_RESET_A20_PORT_ADDR;
        repeat (2) @(posedge clk);
        #1 arst_n = 1;
        step;
        `CHK("gate_por", 1'b1, gate)
        fw_rd(d);
        `CHK("fw_reset", `FIRMWARE_GATE_CONTROL_RESET, d)
        isa_rd(d, o);
        `CHK("port_reset", `FAST_RESET_A20_PORT_RESET, d)
        for (int i = 0; i < 2; i++)
        begin
            kbd(1'b1, `GATE_CMD_BYTE, f);
            `CHK("seq_cmd", 1'b0, f)
            if (i == 1)
                kbd(1'b1, `GATE_CMD_BYTE, f);
            `CHK("seq_cmd_again", 1'b0, f)
            d = 8'($random(seed));
            d[1] = i[0];
            kbd(1'b0, d, f);
            `CHK("seq_data", 1'b0, f)
            `CHK("seq_hidden", 1'b1, sp)
            kbd(1'b1, `GATE_TRAIL_CMD_BYTE, f);
            `CHK("seq_trail", 1'b0, f)
            `CHK("seq_gate", i[0], gate)
            `CHK("cmd_flag", 1'b1, cdf)
        end
        kbd(1'b1, `GATE_CMD_BYTE, f);
        kbd(1'b1, 8'h5A, f);
        `CHK("bad_cmd_full", 1'b1, f)
        `CHK("bad_cmd_gate", 1'b1, gate)
        kbd(1'b1, `GATE_CMD_BYTE, f);
        kbd(1'b0, 8'hFD, f);
        kbd(1'b0, 8'hFF, f);
        `CHK("extra_data_full", 1'b1, f)
        kbd(1'b0, 8'($random(seed)), f);
        `CHK("plain_full", 1'b1, f)
        `CHK("plain_shown", 1'b0, sp)
        `CHK("data_flag", 1'b0, cdf)
        fw_wr(`GATE_LATCH_SET_STROBE_ADDR, 8'($random(seed)));
        fw_rd(d);
        `CHK("strobe_set", 8'h01, d)
        `CHK("fw_valid", 1'b1, vld)
        fw_wr(`GATE_LATCH_CLEAR_STROBE_ADDR, 8'($random(seed)));
        repeat (20) step;
        fw_rd(d);
        `CHK("strobe_clear", 8'h00, d)
        asst = 1;
        fw_wr(`FIRMWARE_GATE_CONTROL_ADDR, 8'hFF);
        `CHK("assist_high", 1'b1, gate)
        fw_wr(`FIRMWARE_GATE_CONTROL_ADDR, 8'hFE);
        fw_wr(`GATE_LATCH_SET_STROBE_ADDR, 8'h00);
        fw_rd(d);
        `CHK("assist_read", 8'h00, d)
        `CHK("assist_low", 1'b0, gate)
        asst = 0;
        fw_rd(d);
        `CHK("latch_read", 8'h01, d)
        fw_wr(`GATE_LATCH_CLEAR_STROBE_ADDR, 8'h00);
        d = 8'($random(seed));
        isa_wr({d[7:2], 2'b10});
        `CHK("alt_gate", 1'b1, gate)
        isa_rd(d, o);
        `CHK("port_read", port_view(8'h02), d)
        `CHK("port_oe", 1'b0, o)
        isa_wr(8'h00);
        `CHK("alt_gate_off", 1'b0, gate)
        pen = 0;
        isa_wr(8'h02);
        isa_rd(d, o);
        `CHK("off_float", 1'b1, o)
        pen = 1;
        `CHK("off_ignored", 1'b0, gate)
        isa_wr(8'h01);
        isa_wr(8'h00);
        isa_wr(8'h01);
        wait_rst(1'b1, n);
        `CHK("pulse_delay", 1'b1, n + 4 >= `RESET_DELAY_CYCLES)
        wait_rst(1'b0, n);
        `CHK("pulse_width", 1'b1, n >= `RESET_WIDTH_CYCLES)
        isa_wr(8'h01);
        seen = 0;
        repeat (6000)
        begin
            step;
            seen = seen | hrst;
        end
        `CHK("no_extra_pulse", 1'b0, seen)
        sys_rst = 1;
        step;
        sys_rst = 0;
        isa_rd(d, o);
        `CHK("sysrst_port", 8'h00, d)
        isa_wr(8'h01);
        wait_rst(1'b1, n);
        `CHK("pulse_rearmed", 1'b1, hrst)
        wait_rst(1'b0, n);
        isa_wr(8'h02);
        por2_n = 0;
        step;
        por2_n = 1;
        isa_rd(d, o);
        `CHK("por2_port", 8'h00, d)
        fire = 1;
        step;
        fire = 0;
        `CHK("kbc_reset", 1'b1, hrst)
        wait_rst(1'b0, n);
        repeat (8)
        begin
            {misc, gpio} = 2'($random(seed));
            step;
            `CHK("pin_mux", misc ? 1'b0 : gpio, pin)
        end
        // second power-on reset while the gate sits low
        arst_n = 0;
        step;
        `CHK("gate_por_again", 1'b1, gate)
        arst_n = 1;
        step;
        report_and_stop;
    end
endmodule : test_a20_gate_fast_reset
`default_nettype wire
